// *** bf_pkg.sv ***
// Function
// - supervision method selectable: current only, position only, or combined
// - current mode: failure if current stays at or above threshold until timer expiry
// - position mode: failure if position never shows open before expiry
// - combined mode: failure if current high and position not open at expiry
// - timer keeps running after trigger drops
// - expiry without detected opening raises the backup trip output
// - detected opening per method stops the timer
// - opening detected while triggers still active enters rejected state
// - rejected state holds without restart while trigger stays active
// - rejected returns to standby once all triggers drop
// - lockout rises with trip and latches independently of trip
// - trigger from selectable trip group plus three extra trigger inputs
package bf_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned DELAY_MS_DEFAULT = 100;
  localparam int unsigned DELAY_W          = 32;
  localparam int unsigned EXTRA_TRIGGERS   = 3;
  localparam int unsigned PARAM_SETS       = 4;
  localparam int unsigned SET_W            = 2;
  localparam int unsigned CUR_W            = 16;

  typedef enum logic [1:0] {
    current_check_method,
    position_check_method,
    combined_check_method
  } method_e;

  typedef enum logic [1:0] {
    all_trips_group,
    external_trips_group,
    current_trips_group,
    no_trips_group
  } trip_group_e;

  typedef enum logic [1:0] {
    st_standby,
    st_running,
    st_rejected,
    st_tripped
  } state_e;

  // trip commands assigned to the supervised breaker
  typedef struct packed {
    logic external_trip;
    logic current_trip;
    logic other_trip;
  } trip_cmds_s;

  // per parameter set settings
  typedef struct packed {
    logic [CUR_W-1:0]   current_release_threshold;
    logic [DELAY_W-1:0] supervision_delay;
  } set_cfg_s;
endpackage

// *** bf_trigger.sv ***
`timescale 1ns/1ps
module bf_trigger #(
  parameter int unsigned N_EXTRA = bf_pkg::EXTRA_TRIGGERS
) (
  input  wire bf_pkg::trip_cmds_s  trips,
  input  wire bf_pkg::trip_group_e group_sel,
  input  wire logic [N_EXTRA-1:0]  extra_trigger_input,
  input  wire logic                blocked,
  input  wire logic                active,
  output logic                     trigger
);
  logic group_hit;

  // group selection then OR with extra inputs, gated by blocking
  always_comb begin
    case (group_sel)
      bf_pkg::all_trips_group:      group_hit = |trips;
      bf_pkg::external_trips_group: group_hit = trips.external_trip;
      bf_pkg::current_trips_group:  group_hit = trips.current_trip;
      default:                      group_hit = 1'b0;
    endcase
    trigger = active && !blocked && (group_hit || (|extra_trigger_input));
  end
endmodule

// *** breaker_failure_unit.sv ***
`timescale 1ns/1ps
module breaker_failure_unit #(
  parameter int unsigned N_EXTRA = bf_pkg::EXTRA_TRIGGERS
) (
  // clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      rst_n,
  // method and trip source selection
  input  wire bf_pkg::method_e                           method,
  input  wire bf_pkg::trip_group_e                       group_sel,
  input  wire bf_pkg::trip_cmds_s                        trips,
  input  wire logic [N_EXTRA-1:0]                        extra_trigger_input,
  input  wire logic                                      blocked,
  input  wire logic                                      active,
  // parameter sets
  input  wire logic [bf_pkg::SET_W-1:0]                  set_sel,
  input  wire bf_pkg::set_cfg_s [bf_pkg::PARAM_SETS-1:0] set_cfg,
  // field measurements
  input  wire logic [bf_pkg::CUR_W-1:0]                  phase_current,
  input  wire logic                                      position_open,
  // operator acknowledge
  input  wire logic                                      lockout_ack,
  // registered results
  output logic                                           backup_trip,
  output logic                                           lockout,
  output logic                                           running,
  output logic                                           rejected
);
  // one step of the supervision timer, sized to the counter
  localparam logic [bf_pkg::DELAY_W-1:0] COUNT_STEP = {{(bf_pkg::DELAY_W-1){1'b0}}, 1'b1};

  // sequencer state and supervision timer
  bf_pkg::state_e                 state;
  bf_pkg::state_e                 next_state;
  logic [bf_pkg::DELAY_W-1:0]     count;
  logic [bf_pkg::DELAY_W-1:0]     next_count;

  // next values of the registered outputs
  logic                           next_backup_trip;
  logic                           next_lockout;
  logic                           next_running;
  logic                           next_rejected;

  // decoded conditions shared by the processes below
  logic                           trigger;
  logic [bf_pkg::CUR_W-1:0]       threshold;
  logic [bf_pkg::DELAY_W-1:0]     delay;
  logic                           current_low;
  logic                           opened;
  logic                           expired;
  logic                           trip_event;
  logic                           trip_clear;
  logic                           ack_allowed;

  // current threshold of the active parameter set
  function automatic logic [bf_pkg::CUR_W-1:0] threshold_of(
    input bf_pkg::set_cfg_s [bf_pkg::PARAM_SETS-1:0] cfg,
    input logic [bf_pkg::SET_W-1:0]                  sel
  );
    return cfg[sel].current_release_threshold;
  endfunction

  // supervision delay of the active parameter set, in clock cycles
  function automatic logic [bf_pkg::DELAY_W-1:0] delay_of(
    input bf_pkg::set_cfg_s [bf_pkg::PARAM_SETS-1:0] cfg,
    input logic [bf_pkg::SET_W-1:0]                  sel
  );
    return cfg[sel].supervision_delay;
  endfunction

  // has the breaker shown it is open, judged by the selected method
  function automatic logic opening_seen(
    input bf_pkg::method_e m,
    input logic            low,
    input logic            pos_open
  );
    logic seen;
    case (m)
      bf_pkg::current_check_method:  seen = low;
      bf_pkg::position_check_method: seen = pos_open;
      // failure needs current high and contacts closed, so either one clears it
      bf_pkg::combined_check_method: seen = low || pos_open;
      // unused code falls back to the current check rather than never opening
      default:                       seen = low;
    endcase
    return seen;
  endfunction

  // trip source selection and gating
  bf_trigger #(
    .N_EXTRA (N_EXTRA)
  ) u_trigger (
    .trips               (trips),
    .group_sel           (group_sel),
    .extra_trigger_input (extra_trigger_input), // extras act even with no group trip
    .blocked             (blocked),
    .active              (active),
    .trigger             (trigger)
  );

  // settings and opening detection; a set switch applies at once, mid-run too
  always_comb begin
    threshold   = threshold_of(set_cfg, set_sel);
    delay       = delay_of(set_cfg, set_sel);
    // strict compare: a current right on the threshold still counts as flowing
    current_low = phase_current < threshold;
    opened      = opening_seen(method, current_low, position_open);
    // counter runs 0..delay, so a delay of d keeps the timer up for d+1 cycles
    expired     = count >= delay;
  end

  // next sequencer state and timer value
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      bf_pkg::st_standby: begin
        // counter parked at zero so every run starts from a clean count
        next_count = '0;
        // only standby accepts a trigger, so a new run never overlaps an old one
        if (trigger) begin
          next_state = bf_pkg::st_running;
        end
      end
      bf_pkg::st_running: begin
        // a trigger drop does not stop the timer; on opening the trigger picks rejected or standby
        if (opened) begin
          next_state = trigger ? bf_pkg::st_rejected : bf_pkg::st_standby;
          next_count = '0;
        end else if (expired) begin
          next_state = bf_pkg::st_tripped;
        end else begin
          next_count = count + COUNT_STEP;
        end
      end
      bf_pkg::st_rejected: begin
        // no restart from here while any trigger stays up
        if (!trigger) begin
          next_state = bf_pkg::st_standby;
        end
      end
      bf_pkg::st_tripped: begin
        // backup trip ends once the breaker opens late or the triggers fall
        // counter keeps its end value; standby clears it
        if (opened || !trigger) begin
          next_state = bf_pkg::st_standby;
        end
      end
      // unreachable code: recover to standby
      default: begin
        next_state = bf_pkg::st_standby;
        next_count = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= bf_pkg::st_standby;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // trip and lockout events of this cycle
  always_comb begin
    // expiry only trips while no opening is seen in the same cycle
    trip_event  = state == bf_pkg::st_running && !opened && expired;
    // late opening or falling triggers end the backup trip
    trip_clear  = state == bf_pkg::st_tripped && (opened || !trigger);
    // an acknowledge never beats a trip raised in the same cycle
    ack_allowed = lockout_ack && !trip_event;
  end

  // next backup trip and lockout; set wins over clear on both
  always_comb begin
    next_backup_trip = backup_trip;
    next_lockout     = lockout;
    // clear first so that a set in the same cycle wins
    if (trip_clear) begin
      next_backup_trip = 1'b0;
    end
    if (trip_event) begin
      next_backup_trip = 1'b1;
    end
    // lockout does not follow the trip: only an acknowledge lowers it
    if (ack_allowed) begin
      next_lockout = 1'b0;
    end
    if (trip_event) begin
      next_lockout = 1'b1;
    end
  end

  // trip and lockout registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      backup_trip <= 1'b0;
      lockout     <= 1'b0;
    end else begin
      backup_trip <= next_backup_trip;
      lockout     <= next_lockout;
    end
  end

  // status flags follow the next state so they line up with the state register
  always_comb begin
    next_running  = next_state == bf_pkg::st_running;
    next_rejected = next_state == bf_pkg::st_rejected;
  end

  // status registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running  <= 1'b0;
      rejected <= 1'b0;
    end else begin
      running  <= next_running;
      rejected <= next_rejected;
    end
  end
endmodule

// *** bf_checker.sv ***
`timescale 1ns/1ps
module bf_checker(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lockout_ack,
  input wire logic backup_trip,
  input wire logic lockout,
  input wire logic running,
  input wire logic rejected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // trip, lockout and state outputs against each other
  chk_lock_with_trip: assert property ($rose(backup_trip) |-> lockout)
    else $error("lockout missing at trip");
  chk_lock_holds: assert property (lockout && !lockout_ack |=> lockout)
    else $error("lockout dropped");
  chk_ack_clears: assert property (lockout_ack && !backup_trip |=>
    !lockout || $rose(backup_trip))
    else $error("lockout kept after ack");
  chk_trip_ends_run: assert property ($rose(backup_trip) |-> $past(running))
    else $error("trip without timer");
  chk_run_rej_apart: assert property (!(running && rejected))
    else $error("running and rejected");
  chk_rej_after_run: assert property ($rose(rejected) |-> $past(running))
    else $error("rejected without run");
  chk_rej_no_rerun: assert property (rejected |=> !running)
    else $error("restart from rejected");
  chk_trip_alone: assert property (backup_trip |-> !running && !rejected)
    else $error("trip overlaps state");
endmodule
bind breaker_failure_unit bf_checker chk(.clk(clk), .rst_n(rst_n), .lockout_ack(lockout_ack),
  .backup_trip(backup_trip), .lockout(lockout), .running(running), .rejected(rejected));

// *** breaker_model.sv ***
`timescale 1ns/1ps
module breaker_model(
  input  wire logic                     clk,
  input  wire logic                     cmd,
  input  wire logic [1:0]               stuck,
  output logic                          position_open,
  output logic [bf_pkg::CUR_W-1:0]      phase_current
);
  logic [1:0] age = 2'h0;
  // opens two cycles after its command; a stuck bit fakes a welded contact
  always @(posedge clk) age <= cmd ? age + 2'(age != 2'h2) : 2'h0;
  assign position_open = age == 2'h2 && !stuck[0];
  assign phase_current = (age == 2'h2 && !stuck[1]) ? '0 : '1;
endmodule

// *** test_breaker_failure_unit.sv ***
`timescale 1ns/1ps
module test_breaker_failure_unit;
  logic clk = 0, rst_n = 0, blocked = 0, active = 1, lockout_ack = 0, cmd = 0, tr;
  bf_pkg::method_e method = bf_pkg::current_check_method;
  bf_pkg::trip_group_e group_sel = bf_pkg::all_trips_group;
  bf_pkg::trip_cmds_s trips = '0;
  logic [2:0] extra_trigger_input = '0, pick[4] = '{3'h1, 3'h4, 3'h2, 3'h0};
  logic [1:0] set_sel = '0, stuck = '0;
  bf_pkg::set_cfg_s [3:0] set_cfg;
  logic [bf_pkg::CUR_W-1:0] phase_current;
  logic position_open, backup_trip, lockout, running, rejected;
  logic [10:0] q[$], e;
  logic [7:0] dur = 0;
  int err_count = 0, checked = 0, seed = 90904, i, n;
  always #12.5 clk = ~clk;
  breaker_failure_unit uut(.clk(clk), .rst_n(rst_n), .method(method), .group_sel(group_sel),
    .trips(trips), .extra_trigger_input(extra_trigger_input), .blocked(blocked),
    .active(active), .set_sel(set_sel), .set_cfg(set_cfg), .phase_current(phase_current),
    .position_open(position_open), .lockout_ack(lockout_ack), .backup_trip(backup_trip),
    .lockout(lockout), .running(running), .rejected(rejected));
  breaker_model bm(.clk(clk), .cmd(cmd), .stuck(stuck), .position_open(position_open),
    .phase_current(phase_current));
  task conclude;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task wait_run(input logic v);
    for (n = 0; n < 40 && running !== v; n++) @(negedge clk);
    if (n == 40) begin
      err_count++;
      conclude;
    end
  endtask
  // timer length counted while running; outcome judged when it stops
  always @(negedge clk) if (running === 1'b1) dur <= dur + 8'h1;
  else if (dur != 0) begin
    e = q.pop_front();
    cmp(e, {dur, backup_trip, lockout, rejected});
    dur <= 0;
  end
  // every method against every stuck pattern, trigger held or pulsed
  initial begin
    for (i = 0; i < 4; i++) set_cfg[i] = '{16'h0100 | 16'($random(seed)), 32'(5 + i)};
    repeat (20) @(negedge clk);
    rst_n = 1;
    for (i = 0; i < 12; i++) begin
      stuck = 2'(i / 3);
      method = bf_pkg::method_e'(i % 3);
      group_sel = bf_pkg::trip_group_e'(i % 4);
      set_sel = 2'($random(seed));
      tr = (i % 3 == 0) ? stuck[1] : (i % 3 == 1) ? stuck[0] : &stuck;
      // a sound breaker opens two edges after its command, so the timer runs two cycles
      q.push_back({tr ? 8'(6 + set_sel) : 8'h2, tr, tr, !tr && !i[0]});
      trips = pick[i % 4];
      extra_trigger_input = (i % 4 == 3) ? 3'h1 << (i % 3) : 3'h0;
      cmd = 1;
      wait_run(1);
      if (i[0]) {trips, extra_trigger_input} = '0;
      wait_run(0);
      repeat (3) @(negedge clk);
      cmp({8'h0, 1'b0, !tr && !i[0], tr}, {8'h0, running, rejected, lockout});
      {trips, extra_trigger_input, cmd} = '0;
      repeat (2) @(negedge clk);
      cmp({10'h0, tr}, {8'h0, backup_trip, rejected, lockout});
      lockout_ack = 1;
      @(negedge clk);
      lockout_ack = 0;
      @(negedge clk);
      cmp(11'h0, {10'h0, lockout});
    end
    for (i = 0; i < 3; i++) begin
      group_sel = bf_pkg::current_trips_group;
      trips = i ? 3'h2 : 3'h4;
      blocked = i == 1;
      active = i != 2;
      repeat (6) @(negedge clk);
      cmp(11'h0, {9'h0, running, rejected});
    end
    conclude;
  end
endmodule
